//--- hw/lwu_pkg.sv
// Package for the wakeup source enable and pin flag block
package lwu_pkg;
  localparam int LWU_PINS = 8;
  localparam int LWU_MODS = 8;
  localparam int LWU_AW = 8;
  // Printed offsets are indices, byte address is index times four
  localparam logic [LWU_AW-1:0] LWU_IDX_PIN_EDGE_LO = 8'h00;
  localparam logic [LWU_AW-1:0] LWU_IDX_PIN_EDGE_HI = 8'h01;
  localparam logic [LWU_AW-1:0] LWU_IDX_MOD_ENABLE = 8'h02;
  localparam logic [LWU_AW-1:0] LWU_IDX_PIN_FLAGS = 8'h03;
  localparam logic [LWU_AW-1:0] LWU_IDX_MOD_FLAGS = 8'h04;
  localparam logic [LWU_AW-1:0] LWU_IDX_IRQ_MASK = 8'h08;
  localparam logic [LWU_AW-1:0] LWU_IDX_CTRL = 8'h09;
  localparam logic [7:0] LWU_RST_BYTE = 8'h00;
  localparam logic [1:0] LWU_EDGE_OFF = 2'h0;
  localparam logic [1:0] LWU_EDGE_RISE = 2'h1;
  localparam logic [1:0] LWU_EDGE_FALL = 2'h2;
  localparam logic [1:0] LWU_EDGE_ANY = 2'h3;
  localparam int LWU_CTRL_ARM_BIT = 0;

  typedef struct packed {
    logic [LWU_AW+1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } lwu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lwu_apb_rsp_t;

  typedef enum logic [1:0] {
    LWU_ST_RUN,
    LWU_ST_ARMED,
    LWU_ST_WOKE
  } lwu_state_t;
endpackage

//--- hw/lwu_pin_detect.sv
// Per-pin edge detector for the external wake pins
`timescale 1ns/10ps
`default_nettype none
module lwu_pin_detect
  import lwu_pkg::*;
(
  input wire logic pclk,
  input wire logic chip_rst_n,
  input wire logic [LWU_PINS-1:0] external_wake_pin,
  input wire logic [2*LWU_PINS-1:0] pin_edge_enable_field,
  output logic [LWU_PINS-1:0] pin_hit
);
  logic [LWU_PINS-1:0] pin_prev;

  always_ff @(posedge pclk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      pin_prev <= '0;
    else
      pin_prev <= external_wake_pin;
  end

  genvar i;
  generate
    for (i = 0; i < LWU_PINS; i++)
    begin : g_pin
      logic [1:0] mode;
      logic rise;
      logic fall;
      assign mode = pin_edge_enable_field[2*i +: 2];
      assign rise = external_wake_pin[i] & ~pin_prev[i];
      assign fall = ~external_wake_pin[i] & pin_prev[i];
      assign pin_hit[i] = (mode == LWU_EDGE_RISE) ? rise :
                          (mode == LWU_EDGE_FALL) ? fall :
                          (mode == LWU_EDGE_ANY) ? (rise | fall) : 1'b0;
    end
  endgenerate
endmodule
`default_nettype wire

//--- hw/lwu_wake_flags.sv
// Wake source enable and pin flag block with APB registers
//
// Overview of operation
// - Eight module enable bits let each internal module flag wake the chip.
// - Enable and pin flag registers reset only on the non-stop chip reset.
// - A pin flag sets when that enabled pin caused a low-leakage exit.
// - Software cannot set pin flags; writing one clears a flag.
// - A pin flag stays set when its pin edge field is later disabled.
// - On stop-mode wake the pin flag marks the reset source and survives.
// - Each pin has a two-bit field: off, rising, falling or any change.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lwu_wake_flags
  import lwu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_rst_n,
  input wire logic low_leak_mode,
  input wire logic [LWU_AW+1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LWU_PINS-1:0] external_wake_pin,
  input wire logic [LWU_MODS-1:0] module_source_flag,
  output logic wake_request,
  output logic irq
);
  // ==========================================================
  // Bus decode
  lwu_apb_req_t req;
  lwu_apb_rsp_t rsp;
  logic [LWU_AW-1:0] idx;
  logic acc;
  logic wr;
  logic hit_elo;
  logic hit_ehi;
  logic hit_men;
  logic hit_pf;
  logic hit_mf;
  logic hit_msk;
  logic hit_ctl;
  logic mapped;

  assign req = '{paddr: paddr, psel: psel, penable: penable,
                 pwrite: pwrite, pwdata: pwdata};
  assign idx = req.paddr[LWU_AW+1:2];
  // Access phase takes two cycles since pready is registered one cycle after acc
  assign acc = req.psel & req.penable & ~pready;
  assign wr = acc & req.pwrite;
  assign hit_elo = idx == LWU_IDX_PIN_EDGE_LO;
  assign hit_ehi = idx == LWU_IDX_PIN_EDGE_HI;
  assign hit_men = idx == LWU_IDX_MOD_ENABLE;
  assign hit_pf = idx == LWU_IDX_PIN_FLAGS;
  assign hit_mf = idx == LWU_IDX_MOD_FLAGS;
  assign hit_msk = idx == LWU_IDX_IRQ_MASK;
  assign hit_ctl = idx == LWU_IDX_CTRL;
  assign mapped = hit_elo | hit_ehi | hit_men | hit_pf | hit_mf |
                  hit_msk | hit_ctl;

  // ==========================================================
  // Registers
  // Chip reset domain: survives the stop-mode wake reset on presetn
  logic [7:0] edge_lo;
  logic [7:0] edge_hi;
  logic [7:0] module_source_enable_bit;
  logic [7:0] pin_source_flag;
  // Bus reset domain: irq_mask, arm, irq and the bus response
  logic [7:0] irq_mask;
  logic arm;
  lwu_state_t state;
  lwu_state_t next_state;
  logic [LWU_PINS-1:0] pin_hit;
  logic [LWU_PINS-1:0] pin_set;
  logic [LWU_PINS-1:0] pin_clr;
  logic [7:0] next_flags;
  logic [LWU_MODS-1:0] mod_hit;
  logic wake_now;

  lwu_pin_detect u_detect (
    .pclk(pclk),
    .chip_rst_n(chip_rst_n),
    .external_wake_pin(external_wake_pin),
    .pin_edge_enable_field({edge_hi, edge_lo}),
    .pin_hit(pin_hit)
  );

  assign mod_hit = module_source_flag & module_source_enable_bit;
  // only a pin that wakes the chip
  assign pin_set = (state == LWU_ST_ARMED) ? pin_hit : '0;
  assign pin_clr = (wr && hit_pf) ? req.pwdata[7:0] : '0;
  // no dependence on the edge field once set
  assign next_flags = (pin_source_flag & ~pin_clr) | pin_set;
  assign wake_now = (state == LWU_ST_ARMED) &&
                    ((|pin_hit) || (|mod_hit));

  always_ff @(posedge pclk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      edge_lo <= LWU_RST_BYTE;
      edge_hi <= LWU_RST_BYTE;
      module_source_enable_bit <= LWU_RST_BYTE;
    end
    else
    begin
      if (wr && hit_elo)
        edge_lo <= req.pwdata[7:0];
      if (wr && hit_ehi)
        edge_hi <= req.pwdata[7:0];
      if (wr && hit_men)
        module_source_enable_bit <= req.pwdata[7:0];
    end
  end

  // flag kept across the wake reset
  always_ff @(posedge pclk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
      pin_source_flag <= LWU_RST_BYTE;
    else
      pin_source_flag <= next_flags;
  end

  // ==========================================================
  // Wake sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      LWU_ST_RUN:
        if (low_leak_mode && arm)
          next_state = LWU_ST_ARMED;
      LWU_ST_ARMED:
        if (wake_now)
          next_state = LWU_ST_WOKE;
        else if (!low_leak_mode)
          next_state = LWU_ST_RUN;
      LWU_ST_WOKE:
        if (!low_leak_mode)
          next_state = LWU_ST_RUN;
      default:
        next_state = LWU_ST_RUN;
    endcase
  end

  // Wake state sits in chip reset so it is not lost to the wake reset
  always_ff @(posedge pclk or negedge chip_rst_n)
  begin
    if (!chip_rst_n)
    begin
      state <= LWU_ST_RUN;
      wake_request <= 1'b0;
    end
    else
    begin
      state <= next_state;
      wake_request <= (next_state == LWU_ST_WOKE);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= LWU_RST_BYTE;
      arm <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && hit_msk)
        irq_mask <= req.pwdata[7:0];
      if (wr && hit_ctl)
        arm <= req.pwdata[LWU_CTRL_ARM_BIT];
      irq <= |(next_flags & irq_mask);
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] rd_byte;
  // module flags are read only here
  assign rd_byte = hit_elo ? edge_lo :
                   hit_ehi ? edge_hi :
                   hit_men ? module_source_enable_bit :
                   hit_pf ? pin_source_flag :
                   hit_mf ? module_source_flag :
                   hit_msk ? irq_mask :
                   hit_ctl ? {7'h00, arm} : 8'h00;
  assign rsp = '{prdata: {24'h000000, rd_byte}, pready: acc,
                 pslverr: acc & ~mapped};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rsp.pready;
      pslverr <= rsp.pslverr;
      if (acc && !req.pwrite)
        prdata <= rsp.prdata;
    end
  end
endmodule
`default_nettype wire

//--- tb/lwu_wake_flags_sva.sv
// Port checker for the wake flag block
`timescale 1ns/10ps
`default_nettype none
module lwu_wake_flags_sva
  import lwu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chip_rst_n,
  input wire logic low_leak_mode,
  input wire logic [LWU_AW+1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [LWU_PINS-1:0] external_wake_pin,
  input wire logic [LWU_MODS-1:0] module_source_flag,
  input wire logic wake_request,
  input wire logic irq
);
  // ====
  // Bus access and wake request checks
  wire acc = psel && penable && !pready;
  wire [7:0] ix = paddr[9:2];
  wire hit = (ix <= 8'h04) || (ix == 8'h08) || (ix == 8'h09);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence rd_done_s;
    acc && !pwrite ##1 pready;
  endsequence
  ready_wait_a: assert property (acc |=> pready)
    else $error("access not answered next cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_map_a: assert property (acc && !hit |=> pslverr)
    else $error("unmapped access not refused");
  ok_map_a: assert property (acc && hit |=> !pslverr)
    else $error("mapped access refused");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  rd_width_a: assert property (rd_done_s |-> prdata[31:8] == 24'h0)
    else $error("read data above byte");
  wake_rst_a: assert property (!chip_rst_n |-> !wake_request)
    else $error("wake request in chip reset");
  wake_mode_a: assert property (wake_request |-> $past(low_leak_mode))
    else $error("wake request outside low leakage mode");
  wake_hold_a: assert property (chip_rst_n && low_leak_mode &&
    $past(wake_request) |-> wake_request)
    else $error("wake request dropped in low leakage mode");
endmodule
`default_nettype wire

//--- tb/lwu_src_model.sv
// Model of the wake pins and peripheral flags
`timescale 1ns/10ps
`default_nettype none
module lwu_src_model (
  input wire logic pclk,
  input wire logic [7:0] tgl,
  input wire logic [7:0] mset,
  input wire logic [7:0] mclr,
  output logic [7:0] external_wake_pin,
  output logic [7:0] module_source_flag
);
  // ====
  // Pin levels and peripheral flags
  initial external_wake_pin = 8'h00;
  initial module_source_flag = 8'h00;
  always @(posedge pclk)
    external_wake_pin <= external_wake_pin ^ tgl;
  always @(posedge pclk)
    module_source_flag <= (module_source_flag | mset) & ~mclr;
endmodule
`default_nettype wire

//--- tb/lwu_wake_flags_test.sv
// Bench for the wake flag block
`timescale 1ns/10ps
`default_nettype none
module lwu_wake_flags_test;
  import lwu_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic chip_rst_n = 1'b0;
  logic low_leak_mode = 1'b0;
  logic [LWU_AW+1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, r;
  logic pready, pslverr, wake_request, irq, sl;
  logic [7:0] external_wake_pin, module_source_flag;
  logic [7:0] tgl = 8'h00, mset = 8'h00, mclr = 8'h00;
  int err_count = 0;
  int n_tests = 0;
  // ====
  // Clock, design and partner
  initial forever #5 pclk = ~pclk;
  lwu_wake_flags DUT (.*);
  lwu_src_model SRC (.*);
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL t=%0t got %h want %h", $time, g, e);
    end
  endtask
  // Callers enter and leave just after a rising edge
  task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] d);
    int k = 0;
    psel <= 1'b1;
    paddr <= {i, 2'b00};
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Values read here are those sampled at this rising edge
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    chk({31'h0, pready}, 32'h1);
    if (k == 20) close_out;
    sl = pslverr;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    xfer(i, 1'b0, 8'h00);
    chk(r, {24'h0, e});
  endtask
  task automatic pulse_rst(input logic chip);
    if (chip)
      chip_rst_n <= 1'b0;
    else
      presetn <= 1'b0;
    @(posedge pclk);
    chip_rst_n <= 1'b1;
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic wait_wake;
    int k = 0;
    while (wake_request !== 1'b1 && k < 40)
    begin
      @(negedge pclk);
      k++;
    end
    @(posedge pclk);
    chk({31'h0, wake_request}, 32'h1);
    if (k == 40) close_out;
  endtask
  // ====
  // Main sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    pulse_rst(1'b1);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    xfer(8'h05, 1'b0, 8'h00);
    chk({31'h0, sl}, 32'h1);
    xfer(8'h02, 1'b1, 8'ha5);
    rd(8'h02, 8'ha5);
    xfer(8'h03, 1'b1, 8'hff);
    rd(8'h03, 8'h00);
    $display("test registers ends");
    // Pin0 off, pin1 rise, pin2 fall, pin3 any change
    xfer(8'h00, 1'b1, 8'he4);
    xfer(8'h09, 1'b1, 8'h01);
    low_leak_mode <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    tgl <= 8'h0f;
    @(posedge pclk);
    tgl <= 8'h00;
    wait_wake;
    low_leak_mode <= 1'b0;
    rd(8'h03, 8'h0a);
    chk({31'h0, wake_request}, 32'h0);
    xfer(8'h08, 1'b1, 8'h02);
    xfer(8'h03, 1'b1, 8'h00);
    chk({31'h0, irq}, 32'h1);
    xfer(8'h00, 1'b1, 8'h00);
    rd(8'h03, 8'h0a);
    pulse_rst(1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(8'h03, 8'h0a);
    rd(8'h02, 8'ha5);
    xfer(8'h03, 1'b1, 8'h08);
    rd(8'h03, 8'h02);
    $display("test pins ends");
    pulse_rst(1'b1);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    // Flag of a disabled module must not wake
    xfer(8'h02, 1'b1, 8'hf7);
    xfer(8'h09, 1'b1, 8'h01);
    low_leak_mode <= 1'b1;
    mset <= 8'h08;
    @(posedge pclk);
    mset <= 8'h00;
    repeat (8) @(posedge pclk);
    chk({31'h0, wake_request}, 32'h0);
    xfer(8'h02, 1'b1, 8'h08);
    wait_wake;
    rd(8'h04, 8'h08);
    rd(8'h03, 8'h00);
    mclr <= 8'h08;
    @(posedge pclk);
    mclr <= 8'h00;
    $display("test modules ends");
    close_out;
  end
endmodule
bind lwu_wake_flags lwu_wake_flags_sva chk_i (.*);
`default_nettype wire
